// File: hdl/hsr_defines.svh
// Offsets, field positions, reset values and fixed counts of the hop slot block.
// Assumes byte addressing on the register bus, one 32-bit word per register.
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH

`define HSR_ADDR_W 8
`define HSR_OFF_CTRL 8'h00
`define HSR_OFF_REPEAT 8'h04
`define HSR_OFF_STATUS 8'h08
`define HSR_OFF_ALLOW_VALID 8'h0c
`define HSR_OFF_ALLOW_BASE 8'h40
`define HSR_ALLOW_N 10

`define HSR_F_MIN 0
`define HSR_F_MAX 4
`define HSR_F_SPEED 8
`define HSR_F_CONT_SEL 10
`define HSR_F_CALLER_OPEN 11
`define HSR_F_RELAY_EN 12
`define HSR_F_ROLE 13
`define HSR_F_REP_PATH 15

`define HSR_F_ST_BUDGET 0
`define HSR_F_ST_WINDOW 8
`define HSR_F_ST_LINK_FAIL 20
`define HSR_F_ST_RELAY_ACT 21
`define HSR_F_ST_RTS_BUSY 22
`define HSR_F_ST_RELAY_LVL 23

`define HSR_RST_MIN 4'h0
`define HSR_RST_MAX 4'h9
`define HSR_RST_SPEED 2'h2
`define HSR_RST_CONT_SEL 1'h1
`define HSR_RST_CALLER_OPEN 1'h0
`define HSR_RST_RELAY_EN 1'h0
`define HSR_RST_REPEAT 8'h03
`define HSR_SIZE_LIMIT 4'h9
`define HSR_SPEED_FAST 2'h2
`define HSR_SPEED_ROBUST 2'h3
`define HSR_R3_MIN_BASE 8'h08

`endif

// File: hdl/hsr_pkg.sv
// Types shared by the hop slot allocation and RTS relay block.
// Assumes nothing beyond a SystemVerilog compiler.
package hsr_pkg;
   typedef enum logic [1:0] {
      HSR_P2P_MASTER = 2'b00,
      HSR_P2P_SLAVE = 2'b01,
      HSR_MP_MASTER = 2'b10,
      HSR_MP_SLAVE = 2'b11
   } hsr_role_t;

   typedef enum logic [1:0] {
      HSR_RTS_IDLE = 2'b00,
      HSR_RTS_AWAIT_ACK = 2'b01,
      HSR_RTS_BROADCAST = 2'b10
   } hsr_rts_t;
endpackage

// File: hdl/hsr_top.sv
// Hop slot allocation, continuous transmit, caller admission and RTS relay.
// Assumes a slot scheduler outside that pulses slot_start before each transmit slot
// and a modem that carries rts status, acks and the slave window over air.
//
// Contract
// - Master sends at most the hop budget chosen by the size settings each hop.
// - Unused master budget goes to slave window on top of reserved bytes.
// - Reserved setting maps to byte counts per air speed table.
// - Air speed 2 master budget comes from printed 10x10 table.
// - Air speed 3 master budget is reserved bytes plus sixteen times limit.
// - Continuous select 0 transmits every hop; 1 transmits on demand.
// - Continuous mode drives CTS, except on a slave with active relay, with on-time rising with signal strength.
// - Air speed accepts 2 or 3; multipoint mismatch with master fails link.
// - Caller check 0 admits listed serials only; 1 admits any caller.
// - Relay enable 1 lets master RTS drive slave CTS; 0 disables.
// - Relay enabled means slave CTS no longer does serial flow control.
// - Master samples RTS before each transmit slot; change sends status.
// - Point-to-point master resends status each slot until slave acknowledges.
// - Multipoint master sends status broadcast repeat count times, no ack.
// - Rts_relay_enable latency follows master slot spacing, 5.9 to 21 ms.
// - Relay is off on point-to-point links passing through a repeater.
`timescale 1ns/1ps
`include "hsr_defines.svh"

module hsr_top
   import hsr_pkg::*;
#(
   parameter int ALLOW_N = `HSR_ALLOW_N
) (
   input wire logic clk_sys,                      // 200 MHz system clock
   input wire logic sys_rst,                      // Asynchronous reset, active high
   input wire logic [`HSR_ADDR_W-1:0] avs_address, // Byte address
   input wire logic avs_read,                     // Read request
   input wire logic avs_write,                    // Write request
   input wire logic [31:0] avs_writedata,         // Write data
   input wire logic [3:0] avs_byteenable,         // Byte lanes
   output logic [31:0] avs_readdata,              // Read data
   output logic avs_waitrequest,                  // Stall until answer
   input wire logic slot_start,                   // Pulse just before own transmit slot
   input wire logic [7:0] tx_pending,             // Bytes waiting to go out
   input wire logic [8:0] rx_window,              // Window granted to this slave
   output logic tx_go,                            // Pulse: transmit in this slot
   output logic [7:0] tx_bytes,                   // Payload bytes for this slot
   output logic [8:0] slave_window,               // Window handed to the slave
   output logic tx_rts_msg,                       // Status message rides this slot
   output logic tx_rts_level,                     // RTS level in that message
   input wire logic rts_in,                       // Serial RTS input of the master
   input wire logic rx_rts_ack,                   // Pulse: slave acked status
   input wire logic rx_rts_msg,                   // Pulse: status message received
   input wire logic rx_rts_level,                 // Level in received message
   output logic tx_rts_ack,                       // Pulse: ack to the master
   input wire logic fc_cts_in,                    // Flow-control CTS from serial path
   input wire logic [7:0] rssi,                   // Received signal strength
   output logic cts_out,                          // CTS pin level
   input wire logic peer_speed_valid,             // Master speed heard this cycle
   input wire logic [1:0] peer_speed,             // Air speed of the master
   output logic link_fail,                        // Multipoint speed mismatch
   input wire logic call_req,                     // Pulse: incoming call
   input wire logic [31:0] call_serial,           // Serial number of caller
   output logic call_accept,                      // Pulse: call admitted
   output logic call_reject                       // Pulse: call refused
);
   import hsr_pkg::*;

   // Speed 2 hop budget, index reserved*10 + limit; entry 92 is irregular on purpose
   localparam logic [7:0] BUDGET2 [100] = '{
      8'h0f, 8'h24, 8'h3a, 8'h4f, 8'h64, 8'h79, 8'h8f, 8'ha4, 8'hb9, 8'hce,
      8'h14, 8'h2a, 8'h3f, 8'h54, 8'h69, 8'h7f, 8'h94, 8'ha9, 8'hbe, 8'hd4,
      8'h1a, 8'h2f, 8'h44, 8'h5a, 8'h6f, 8'h84, 8'h99, 8'haf, 8'hc4, 8'hd9,
      8'h1f, 8'h34, 8'h4a, 8'h5f, 8'h74, 8'h89, 8'h9f, 8'hb4, 8'hc9, 8'hde,
      8'h24, 8'h3a, 8'h4f, 8'h64, 8'h79, 8'h8f, 8'ha4, 8'hb9, 8'hce, 8'he4,
      8'h2a, 8'h3f, 8'h54, 8'h69, 8'h7f, 8'h94, 8'ha9, 8'hbe, 8'hd4, 8'he9,
      8'h2f, 8'h44, 8'h5a, 8'h6f, 8'h84, 8'h99, 8'haf, 8'hc4, 8'hd9, 8'hee,
      8'h34, 8'h4a, 8'h5f, 8'h74, 8'h89, 8'h9f, 8'hb4, 8'hc9, 8'hde, 8'hf4,
      8'h3a, 8'h4f, 8'h64, 8'h79, 8'h8f, 8'ha4, 8'hb9, 8'hce, 8'he4, 8'hf9,
      8'h3f, 8'h54, 8'h5f, 8'h7f, 8'h94, 8'ha9, 8'hbe, 8'hd4, 8'he9, 8'hfe
   };
   localparam logic [7:0] MIN2 [10] = '{
      8'h10, 8'h15, 8'h1a, 8'h20, 8'h25, 8'h2a, 8'h30, 8'h35, 8'h3a, 8'h40
   };

   // Configuration and bus state
   logic [3:0] min_r, min_nxt;
   logic [3:0] max_r, max_nxt;
   logic [1:0] speed_r, speed_nxt;
   logic cont_sel_r, cont_sel_nxt;
   logic caller_open_r, caller_open_nxt;
   logic relay_en_r, relay_en_nxt;
   hsr_role_t role_r, role_nxt;
   logic rep_path_r, rep_path_nxt;
   logic [7:0] repeat_r, repeat_nxt;
   logic [ALLOW_N-1:0] allow_valid_r, allow_valid_nxt;
   logic [31:0] allow_r [ALLOW_N];
   logic [31:0] allow_nxt [ALLOW_N];
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // Link-side state
   hsr_rts_t rts_st_r, rts_st_nxt;
   logic sent_lvl_r, sent_lvl_nxt;
   logic [7:0] bc_cnt_r, bc_cnt_nxt;
   logic tx_go_r, tx_go_nxt;
   logic [7:0] tx_bytes_r, tx_bytes_nxt;
   logic [8:0] win_r, win_nxt;
   logic rts_msg_r, rts_msg_nxt;
   logic rts_lvl_r, rts_lvl_nxt;
   logic ack_out_r, ack_out_nxt;
   logic relay_lvl_r, relay_lvl_nxt;
   logic fail_r, fail_nxt;
   logic [7:0] pwm_r, pwm_nxt;
   logic cts_r, cts_nxt;
   logic acc_r, acc_nxt;
   logic rej_r, rej_nxt;

   logic is_master, is_mp, relay_act, cont_mode, listed;
   logic [7:0] min_bytes, budget;
   logic [ALLOW_N-1:0] hit;
   logic [3:0] wmin, wmax;
   logic [1:0] wspeed;

   assign is_master = (role_r == HSR_P2P_MASTER) || (role_r == HSR_MP_MASTER);
   assign is_mp = (role_r == HSR_MP_MASTER) || (role_r == HSR_MP_SLAVE);
   assign relay_act = relay_en_r && (is_mp || !rep_path_r);
   assign cont_mode = (cont_sel_r == 1'b0);

   // Byte budgets follow the air speed
   always_comb begin
      if (speed_r == `HSR_SPEED_FAST) begin
         min_bytes = MIN2[min_r];
         budget = BUDGET2[7'(min_r) * 7'd10 + 7'(max_r)];
      end else begin
         min_bytes = `HSR_R3_MIN_BASE + {2'h0, min_r, 2'h0};
         budget = min_bytes + {max_r, 4'h0};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < ALLOW_N; gi++) begin : g_allow
         assign hit[gi] = allow_valid_r[gi] && (allow_r[gi] == call_serial);
      end
   endgenerate
   assign listed = |hit;

   // Answer comes one edge after the request is seen, so decode has a full cycle
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = rdata_r;
   assign wmin = avs_writedata[`HSR_F_MIN +: 4];
   assign wmax = avs_writedata[`HSR_F_MAX +: 4];
   assign wspeed = avs_writedata[`HSR_F_SPEED +: 2];

   always_comb begin
      min_nxt = min_r;
      max_nxt = max_r;
      speed_nxt = speed_r;
      cont_sel_nxt = cont_sel_r;
      caller_open_nxt = caller_open_r;
      relay_en_nxt = relay_en_r;
      role_nxt = role_r;
      rep_path_nxt = rep_path_r;
      repeat_nxt = repeat_r;
      allow_valid_nxt = allow_valid_r;
      allow_nxt = allow_r;
      ack_nxt = (avs_read || avs_write) && !ack_r;
      rdata_nxt = rdata_r;
      if (avs_read && !ack_r) begin
         rdata_nxt = 32'h0;
         if (avs_address == `HSR_OFF_CTRL) begin
            rdata_nxt[`HSR_F_MIN +: 4] = min_r;
            rdata_nxt[`HSR_F_MAX +: 4] = max_r;
            rdata_nxt[`HSR_F_SPEED +: 2] = speed_r;
            rdata_nxt[`HSR_F_CONT_SEL] = cont_sel_r;
            rdata_nxt[`HSR_F_CALLER_OPEN] = caller_open_r;
            rdata_nxt[`HSR_F_RELAY_EN] = relay_en_r;
            rdata_nxt[`HSR_F_ROLE +: 2] = role_r;
            rdata_nxt[`HSR_F_REP_PATH] = rep_path_r;
         end else if (avs_address == `HSR_OFF_REPEAT) begin
            rdata_nxt[7:0] = repeat_r;
         end else if (avs_address == `HSR_OFF_STATUS) begin
            rdata_nxt[`HSR_F_ST_BUDGET +: 8] = budget;
            rdata_nxt[`HSR_F_ST_WINDOW +: 9] = win_r;
            rdata_nxt[`HSR_F_ST_LINK_FAIL] = fail_r;
            rdata_nxt[`HSR_F_ST_RELAY_ACT] = relay_act;
            rdata_nxt[`HSR_F_ST_RTS_BUSY] = (rts_st_r != HSR_RTS_IDLE);
            rdata_nxt[`HSR_F_ST_RELAY_LVL] = relay_lvl_r;
         end else if (avs_address == `HSR_OFF_ALLOW_VALID) begin
            rdata_nxt[ALLOW_N-1:0] = allow_valid_r;
         end
         for (int i = 0; i < ALLOW_N; i++) begin
            if (avs_address == `HSR_OFF_ALLOW_BASE + 8'(4 * i)) begin
               rdata_nxt = allow_r[i];
            end
         end
      end
      // Writes take effect at the edge where waitrequest is low
      if (avs_write && ack_r) begin
         if (avs_address == `HSR_OFF_CTRL) begin
            if (avs_byteenable[0]) begin
               if (wmin <= `HSR_SIZE_LIMIT) begin
                  min_nxt = wmin;
               end
               if (wmax <= `HSR_SIZE_LIMIT) begin
                  max_nxt = wmax;
               end
            end
            if (avs_byteenable[1]) begin
               if (wspeed == `HSR_SPEED_FAST || wspeed == `HSR_SPEED_ROBUST) begin
                  speed_nxt = wspeed;
               end
               cont_sel_nxt = avs_writedata[`HSR_F_CONT_SEL];
               caller_open_nxt = avs_writedata[`HSR_F_CALLER_OPEN];
               relay_en_nxt = avs_writedata[`HSR_F_RELAY_EN];
               role_nxt = hsr_role_t'(avs_writedata[`HSR_F_ROLE +: 2]);
               rep_path_nxt = avs_writedata[`HSR_F_REP_PATH];
            end
         end else if (avs_address == `HSR_OFF_REPEAT && avs_byteenable[0]) begin
            repeat_nxt = avs_writedata[7:0];
         end else if (avs_address == `HSR_OFF_ALLOW_VALID) begin
            allow_valid_nxt = avs_writedata[ALLOW_N-1:0];
         end
         for (int i = 0; i < ALLOW_N; i++) begin
            if (avs_address == `HSR_OFF_ALLOW_BASE + 8'(4 * i)) begin
               for (int b = 0; b < 4; b++) begin
                  if (avs_byteenable[b]) begin
                     allow_nxt[i][8*b +: 8] = avs_writedata[8*b +: 8];
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         min_r <= `HSR_RST_MIN;
         max_r <= `HSR_RST_MAX;
         speed_r <= `HSR_RST_SPEED;
         cont_sel_r <= `HSR_RST_CONT_SEL;
         caller_open_r <= `HSR_RST_CALLER_OPEN;
         relay_en_r <= `HSR_RST_RELAY_EN;
         role_r <= HSR_P2P_MASTER;
         rep_path_r <= 1'b0;
         repeat_r <= `HSR_RST_REPEAT;
         allow_valid_r <= '0;
         for (int i = 0; i < ALLOW_N; i++) begin
            allow_r[i] <= 32'h0;
         end
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         min_r <= min_nxt;
         max_r <= max_nxt;
         speed_r <= speed_nxt;
         cont_sel_r <= cont_sel_nxt;
         caller_open_r <= caller_open_nxt;
         relay_en_r <= relay_en_nxt;
         role_r <= role_nxt;
         rep_path_r <= rep_path_nxt;
         repeat_r <= repeat_nxt;
         allow_valid_r <= allow_valid_nxt;
         allow_r <= allow_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Slot, relay and admission logic
   always_comb begin
      logic [7:0] lim;
      logic [7:0] grant;
      logic send;
      lim = 8'h0;
      grant = 8'h0;
      send = 1'b0;
      rts_st_nxt = rts_st_r;
      sent_lvl_nxt = sent_lvl_r;
      bc_cnt_nxt = bc_cnt_r;
      tx_go_nxt = 1'b0;
      tx_bytes_nxt = tx_bytes_r;
      win_nxt = win_r;
      rts_msg_nxt = 1'b0;
      rts_lvl_nxt = rts_lvl_r;
      ack_out_nxt = 1'b0;
      relay_lvl_nxt = relay_lvl_r;
      fail_nxt = fail_r;
      pwm_nxt = pwm_r + 8'h01;
      acc_nxt = 1'b0;
      rej_nxt = 1'b0;
      // An ack seen in a slot cycle still stops that slot's resend
      if (rx_rts_ack && rts_st_r == HSR_RTS_AWAIT_ACK) begin
         rts_st_nxt = HSR_RTS_IDLE;
      end
      if (!relay_act) begin
         rts_st_nxt = HSR_RTS_IDLE;
         sent_lvl_nxt = rts_in;
      end
      // Slot cadence is the scheduler's; RTS latency is bounded by its spacing
      if (slot_start) begin
         lim = is_master ? budget : (rx_window > 9'h0ff ? 8'hff : rx_window[7:0]);
         grant = (tx_pending < lim) ? tx_pending : lim;
         if (is_master && relay_act) begin
            if (rts_in != sent_lvl_r) begin
               send = 1'b1;
               sent_lvl_nxt = rts_in;
               if (is_mp) begin
                  rts_st_nxt = (repeat_r > 8'h01) ? HSR_RTS_BROADCAST : HSR_RTS_IDLE;
                  bc_cnt_nxt = repeat_r - 8'h01;
               end else begin
                  rts_st_nxt = HSR_RTS_AWAIT_ACK;
               end
            end else begin
               unique case (rts_st_nxt)
                  HSR_RTS_IDLE: begin
                  end
                  HSR_RTS_AWAIT_ACK: begin
                     send = 1'b1;
                  end
                  HSR_RTS_BROADCAST: begin
                     send = 1'b1;
                     bc_cnt_nxt = bc_cnt_r - 8'h01;
                     if (bc_cnt_r == 8'h01) begin
                        rts_st_nxt = HSR_RTS_IDLE;
                     end
                  end
                  default: begin
                     rts_st_nxt = HSR_RTS_IDLE;
                  end
               endcase
            end
         end
         tx_bytes_nxt = grant;
         rts_msg_nxt = send;
         // Level only moves with a message, so the far side never sees a silent change
         if (send) begin
            rts_lvl_nxt = sent_lvl_nxt;
         end
         tx_go_nxt = cont_mode || (grant != 8'h0) || send;
         if (is_master) begin
            win_nxt = {1'b0, min_bytes} + {1'b0, budget - grant};
         end
      end
      if (!is_master && rx_rts_msg) begin
         if (relay_act) begin
            relay_lvl_nxt = rx_rts_level;
         end
         ack_out_nxt = !is_mp;
      end
      if (is_mp && !is_master && peer_speed_valid) begin
         fail_nxt = (peer_speed != speed_r);
      end else if (!is_mp || is_master) begin
         fail_nxt = 1'b0;
      end
      // Relay overrides the diagnostic display, which overrides flow control
      if (!is_master && relay_act) begin
         cts_nxt = relay_lvl_r;
      end else if (cont_mode) begin
         cts_nxt = (rssi == 8'hff) || (pwm_r < rssi);
      end else begin
         cts_nxt = fc_cts_in;
      end
      if (call_req && !is_master) begin
         acc_nxt = caller_open_r || listed;
         rej_nxt = !(caller_open_r || listed);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rts_st_r <= HSR_RTS_IDLE;
         sent_lvl_r <= 1'b0;
         bc_cnt_r <= 8'h0;
         tx_go_r <= 1'b0;
         tx_bytes_r <= 8'h0;
         win_r <= 9'h0;
         rts_msg_r <= 1'b0;
         rts_lvl_r <= 1'b0;
         ack_out_r <= 1'b0;
         relay_lvl_r <= 1'b0;
         fail_r <= 1'b0;
         pwm_r <= 8'h0;
         cts_r <= 1'b0;
         acc_r <= 1'b0;
         rej_r <= 1'b0;
      end else begin
         rts_st_r <= rts_st_nxt;
         sent_lvl_r <= sent_lvl_nxt;
         bc_cnt_r <= bc_cnt_nxt;
         tx_go_r <= tx_go_nxt;
         tx_bytes_r <= tx_bytes_nxt;
         win_r <= win_nxt;
         rts_msg_r <= rts_msg_nxt;
         rts_lvl_r <= rts_lvl_nxt;
         ack_out_r <= ack_out_nxt;
         relay_lvl_r <= relay_lvl_nxt;
         fail_r <= fail_nxt;
         pwm_r <= pwm_nxt;
         cts_r <= cts_nxt;
         acc_r <= acc_nxt;
         rej_r <= rej_nxt;
      end
   end

   assign tx_go = tx_go_r;
   assign tx_bytes = tx_bytes_r;
   assign slave_window = win_r;
   assign tx_rts_msg = rts_msg_r;
   assign tx_rts_level = rts_lvl_r;
   assign tx_rts_ack = ack_out_r;
   assign cts_out = cts_r;
   assign link_fail = fail_r;
   assign call_accept = acc_r;
   assign call_reject = rej_r;
endmodule

// File: test/hsr_top_props.sv
// Port-level checker for the hop slot block.
// Assumes a bind onto hsr_top from the bench top file.
`timescale 1ns/1ps
module hsr_top_props #(
   parameter int ALLOW_N = 10
) (
   input wire logic clk_sys, // Clock
   input wire logic sys_rst, // Reset
   input wire logic slot_start, // Slot pulse
   input wire logic [7:0] tx_pending, // Pending bytes
   input wire logic tx_go, // Transmit pulse
   input wire logic [7:0] tx_bytes, // Bytes sent
   input wire logic [8:0] slave_window, // Slave window
   input wire logic tx_rts_msg, // Status message
   input wire logic tx_rts_level, // Status level
   input wire logic rx_rts_msg, // Received status
   input wire logic tx_rts_ack, // Ack out
   input wire logic peer_speed_valid, // Speed heard
   input wire logic link_fail, // Link failure
   input wire logic call_req, // Call
   input wire logic call_accept, // Accept
   input wire logic call_reject // Reject
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_go_from_slot: assert property (tx_go |-> $past(slot_start))
      else $error("transmit without a slot");
   a_bytes_in_budget: assert property (tx_go |->
      tx_bytes <= $past(tx_pending) && tx_bytes <= 8'hfe)
      else $error("transmit bytes over pending or budget");
   a_alloc_held: assert property (!$past(slot_start) |-> $stable(tx_bytes) && $stable(slave_window))
      else $error("allocation changed between slots");
   a_msg_in_slot: assert property (tx_rts_msg |-> tx_go)
      else $error("status message outside a slot");
   a_level_by_msg: assert property ($changed(tx_rts_level) |-> tx_rts_msg)
      else $error("status level changed without message");
   a_ack_after_msg: assert property (tx_rts_ack |-> $past(rx_rts_msg))
      else $error("ack without a received message");
   a_call_answer: assert property (call_accept || call_reject |->
      $past(call_req) && !(call_accept && call_reject))
      else $error("call answer without a single cause");
   a_fail_cause: assert property ($rose(link_fail) |-> $past(peer_speed_valid))
      else $error("link failure without a heard speed");
endmodule

// File: test/hsr_peer.sv
// Far radio model: acks status messages, sends status to a slave, reports its air speed.
// Assumes the bench sets ack_en, lat and spd and calls send for slave tests.
`timescale 1ns/1ps
module hsr_peer (
   input wire logic clk_sys, // Clock
   input wire logic tx_go, // Our slot fired
   input wire logic tx_rts_msg, // Status rides it
   input wire logic ack_en, // Peer answers at all
   input wire logic [3:0] lat, // Ack delay in cycles, at least 1
   input wire logic [1:0] spd, // Peer air speed
   output logic rx_rts_ack, // Ack pulse
   output logic rx_rts_msg, // Status pulse
   output logic rx_rts_level, // Status level
   output logic peer_speed_valid, // Speed heard
   output logic [1:0] peer_speed // Speed value
);
   int cnt = 0;
   logic [1:0] ph = 2'h0;
   initial begin
      rx_rts_msg = 1'b0;
      rx_rts_level = 1'b0;
   end
   // Speed is heard in bursts, so link_fail must wait for a valid strobe
   assign peer_speed_valid = (ph == 2'h0);
   assign peer_speed = spd;
   always @(posedge clk_sys) begin
      ph <= ph + 2'h1;
      rx_rts_ack <= (cnt == 1) && !(tx_go && tx_rts_msg && ack_en);
      if (tx_go && tx_rts_msg && ack_en) begin
         cnt <= lat;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   task automatic send(input logic lvl);
      @(posedge clk_sys);
      rx_rts_msg <= 1'b1;
      rx_rts_level <= lvl;
      @(posedge clk_sys);
      rx_rts_msg <= 1'b0;
      rx_rts_level <= ~lvl; // Released, so the old level must not linger
   endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the hop slot block with a peer radio model.
// Assumes hsr_pkg, hsr_top, hsr_peer and hsr_top_props are compiled first.
`timescale 1ns/1ps
`include "hsr_defines.svh"
module tb;
   logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, slot_start = 0;
   logic [7:0] avs_address = 0, tx_pending = 0, rssi = 0, tx_bytes;
   logic [31:0] avs_writedata = 0, call_serial = 0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf, lat = 4'h1;
   logic [8:0] rx_window = 0, slave_window;
   logic [1:0] spd = 2'h2, peer_speed;
   logic rts_in = 0, fc_cts_in = 0, call_req = 0, ack_en = 0, avs_waitrequest, tx_go;
   logic tx_rts_msg, tx_rts_level, rx_rts_ack, rx_rts_msg, rx_rts_level, tx_rts_ack;
   logic cts_out, peer_speed_valid, link_fail, call_accept, call_reject;
   int errors = 0, num_checks = 0, cyc = 0, seed = 32'h5f6123cd;
   logic [31:0] expq[$];
   logic [7:0] mb2[10] = '{16, 21, 26, 32, 37, 42, 48, 53, 58, 64};
   hsr_top u_hsr_top (.*);
   hsr_peer u_hsr_peer (.*);
   always #2.5 clk_sys = ~clk_sys;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pop(input string nm, input logic [31:0] g);
      chk(nm, expq.size() ? expq.pop_front() : 32'hx, g);
   endtask
   // Outputs are settled mid-cycle, so the watcher samples on the falling edge
   always @(negedge clk_sys) if (!sys_rst) begin
      if (avs_read && !avs_waitrequest) pop("readdata", avs_readdata);
      if (tx_go) pop("slot", {13'h0, tx_rts_msg, tx_rts_level, slave_window, tx_bytes});
      if (call_accept || call_reject) pop("call", {30'h0, call_accept, call_reject});
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   function automatic logic [31:0] cw(input int mn, mx, sp, cs, op, re, ro);
      return mn | mx << 4 | sp << 8 | cs << 10 | op << 11 | re << 12 | ro << 13;
   endfunction
   function automatic logic [31:0] es(input logic m, l, input int mb, bud, p);
      int b;
      b = p < bud ? p : bud;
      return {13'h0, m, l, 9'(mb + bud - b), 8'(b)};
   endfunction
   task automatic slot(input logic [7:0] p, input logic [31:0] e, input bit go = 1'b1);
      if (go) expq.push_back(e);
      tx_pending <= p;
      slot_start <= 1'b1;
      @(posedge clk_sys);
      slot_start <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic cts(input logic e);
      repeat (4) @(posedge clk_sys);
      repeat (4) begin
         @(negedge clk_sys);
         chk("cts_out", e, cts_out);
      end
      @(posedge clk_sys);
   endtask
   task automatic call(input logic [31:0] s, input logic [1:0] e);
      expq.push_back(e);
      call_serial <= s;
      call_req <= 1'b1;
      @(posedge clk_sys);
      call_req <= 1'b0;
      call_serial <= ~s;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic end_sim();
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      int t2[6][3] = '{'{0, 0, 15}, '{9, 9, 254}, '{9, 2, 95}, '{3, 5, 137}, '{0, 9, 206},
                       '{5, 0, 42}};
      int mn, mx, p;
      logic [31:0] s;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rd(`HSR_OFF_CTRL, 32'h0000_0690);
      rd(`HSR_OFF_REPEAT, 32'h0000_0003);
      rd(8'h20, 32'h0000_0000);
      bus(1'b1, `HSR_OFF_CTRL, cw(10, 15, 1, 1, 0, 0, 0));
      rd(`HSR_OFF_CTRL, 32'h0000_0690);
      for (int i = 0; i < 6; i++) begin
         p = {$random(seed)} % 256;
         bus(1'b1, `HSR_OFF_CTRL, cw(t2[i][0], t2[i][1], 2, 0, 0, 0, 0));
         slot(p, es(0, 0, mb2[t2[i][0]], t2[i][2], p));
      end
      for (int i = 0; i < 8; i++) begin
         mn = i ? {$random(seed)} % 10 : 9;
         mx = i ? {$random(seed)} % 10 : 9;
         p = {$random(seed)} % 256;
         bus(1'b1, `HSR_OFF_CTRL, cw(mn, mx, 3, 0, 0, 0, 0));
         slot(p, es(0, 0, 8 + 4 * mn, 8 + 4 * mn + 16 * mx, p));
      end
      rssi <= 8'hff;
      cts(1'b1);
      rssi <= 8'h00;
      cts(1'b0);
      fc_cts_in <= 1'b1;
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 1, 0, 1, 0));
      cts(1'b1);
      slot(8'h05, es(0, 0, 64, 254, 5));
      slot(8'h00, 32'h0, 1'b0);
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 0, 0, 1, 0));
      rts_in <= 1'b1;
      slot(8'h00, es(1, 1, 64, 254, 0));
      slot(8'h00, es(1, 1, 64, 254, 0));
      ack_en <= 1'b1;
      slot(8'h00, es(1, 1, 64, 254, 0));
      slot(8'h00, es(0, 1, 64, 254, 0));
      ack_en <= 1'b0;
      bus(1'b1, `HSR_OFF_REPEAT, 32'h2);
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 0, 0, 1, 2));
      rts_in <= 1'b0;
      slot(8'h00, es(1, 0, 64, 254, 0));
      slot(8'h00, es(1, 0, 64, 254, 0));
      slot(8'h00, es(0, 0, 64, 254, 0));
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 0, 0, 1, 0) | 32'h8000);
      rts_in <= 1'b1;
      slot(8'h00, es(0, 0, 64, 254, 0));
      fc_cts_in <= 1'b0;
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 1, 0, 1, 1));
      u_hsr_peer.send(1'b1);
      @(negedge clk_sys);
      chk("tx_rts_ack", 1'b1, tx_rts_ack);
      cts(1'b1);
      u_hsr_peer.send(1'b0);
      cts(1'b0);
      s = $random(seed);
      bus(1'b1, `HSR_OFF_ALLOW_BASE, s);
      bus(1'b1, `HSR_OFF_ALLOW_VALID, 32'h1);
      call(s, 2'b10);
      call(s ^ 32'h1, 2'b01);
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 1, 1, 0, 1));
      call(s ^ 32'h1, 2'b10);
      bus(1'b1, `HSR_OFF_CTRL, cw(9, 9, 2, 1, 0, 0, 3));
      spd <= 2'h3;
      cts(1'b0);
      chk("link_fail", 1'b1, link_fail);
      spd <= 2'h2;
      cts(1'b0);
      chk("link_fail", 1'b0, link_fail);
      chk("notes_left", 32'h0, expq.size());
      end_sim();
   end
endmodule
bind hsr_top hsr_top_props #(.ALLOW_N(ALLOW_N)) u_hsr_top_props (.*);
